/* File: design/drive_param_control_bank.sv */
// fieldbus parameter bank of a servo drive: control, mode, status, source, encoder
// What this block does
// - control word bits decode to drive commands
// - signed mode select, only listed codes
// - status word carries state and flags
// - status bits 13-15 position, bit14, reference
// - command source codes 0 to 3
// - source change waits for power-on, except first
// - encoder position limited per sensor type
// - encoder position applies at next switch-on
// - position change also moves index pulses
// - legacy firmware: power-of-two resolutions only
// - newer firmware: resolution 8 to 65535
`timescale 1ns/10ps
module drive_param_control_bank #(
    parameter int usr_per_rev = drive_param_pkg::USR_PER_REV,
    parameter int multi_turns = drive_param_pkg::MULTI_TURNS
) (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [15:0] par_addr,
    input  wire logic        par_wr,
    input  wire logic        par_rd,
    input  wire logic [31:0] par_wdata,
    output logic      [31:0] par_rdata,
    output logic             par_ack,
    output logic             par_err,
    input  wire logic        switch_on,
    input  wire logic        multi_turn_sensor,
    input  wire logic        legacy_firmware,
    input  wire logic [5:0]  state_bits,
    input  wire logic        voltage_enabled,
    input  wire logic        warning,
    input  wire logic        target_reached,
    input  wire logic        mode_specific,
    input  wire logic        position_error,
    input  wire logic        status_bit14,
    input  wire logic        reference_valid,
    output logic             ctl_switch_on,
    output logic             ctl_enable_voltage,
    output logic             ctl_quick_stop,
    output logic             ctl_enable_operation,
    output logic      [2:0]  ctl_mode_bits,
    output logic             ctl_fault_reset,
    output logic             ctl_halt,
    output logic      [15:0] op_mode,
    output logic      [1:0]  cmd_source,
    output logic      [31:0] enc_pos_value,
    output logic             enc_pos_load,
    output logic      [31:0] index_offset,
    output logic      [15:0] encoder_simulation_output_resolution
);
    typedef struct packed {
        logic [8:0]  ctl;
        logic [15:0] mode;
        logic [15:0] status;
        logic [1:0]  src_sel;
        logic [1:0]  src_act;
        logic [31:0] enc_pend;
        logic [31:0] enc_pos;
        logic [31:0] idx;
        logic        enc_load;
        logic [15:0] encoder_simulation_output;
        logic [31:0] rdata;
        logic        ack;
        logic        err;
    } state_s;

    localparam logic [31:0] rev_w     = 32'(usr_per_rev);
    localparam logic [31:0] st_max    = 32'(usr_per_rev - 1);
    localparam logic [31:0] mt_max    = 32'(64'(usr_per_rev) * 64'(multi_turns) - 64'd1);

    state_s state_r;
    state_s state_nxt;
    logic        wr_ok;
    logic [31:0] enc_max;
    logic [15:0] wlo;

    // value checks for each writable parameter
    always_comb
    begin
        wlo     = par_wdata[15:0];
        enc_max = multi_turn_sensor ? mt_max : st_max;
        wr_ok   = 1'b0;
        case (par_addr)
            drive_param_pkg::ADDR_CTL_WORD: wr_ok = 1'b1;
            drive_param_pkg::ADDR_OP_MODE:
            begin
                case (wlo)
                    drive_param_pkg::MODE_PROFILE_POS, drive_param_pkg::MODE_PROFILE_VEL,
                    drive_param_pkg::MODE_HOMING, drive_param_pkg::MODE_JOG,
                    drive_param_pkg::MODE_ELEC_GEAR, drive_param_pkg::MODE_CURRENT,
                    drive_param_pkg::MODE_SPEED, drive_param_pkg::MODE_OSCILLATOR:
                        wr_ok = 1'b1;
                    default: wr_ok = 1'b0;
                endcase
            end
            drive_param_pkg::ADDR_CMD_SRC: wr_ok = (wlo <= drive_param_pkg::SRC_MAX);
            drive_param_pkg::ADDR_ENC_POS: wr_ok = (par_wdata <= enc_max);
            drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES:
            begin
                if (legacy_firmware)
                    wr_ok = ((wlo & (wlo - 16'h0001)) == 16'h0000)
                        && (wlo >= drive_param_pkg::ENCODER_SIMULATION_OUTPUT_LEG_MIN)
                        && (wlo <= drive_param_pkg::ENCODER_SIMULATION_OUTPUT_LEG_MAX);
                else
                    wr_ok = (wlo >= drive_param_pkg::ENCODER_SIMULATION_OUTPUT_MIN);
            end
            default: wr_ok = 1'b0; // status word and unmapped addresses
        endcase
    end

    // next-state: parameter writes, reads, switch-on transfer, status capture
    always_comb
    begin
        state_nxt          = state_r;
        state_nxt.ack      = par_wr | par_rd;
        state_nxt.err      = 1'b0;
        state_nxt.enc_load = 1'b0;
        // status rebuilt every cycle from drive state; never from a write
        state_nxt.status = {reference_valid, status_bit14, position_error,
                            mode_specific, 1'b0, target_reached,
                            (state_r.src_act == drive_param_pkg::SRC_CANOPEN)
                                || (state_r.src_act == drive_param_pkg::SRC_MODBUS),
                            state_r.ctl[drive_param_pkg::CW_HALT], warning,
                            state_bits[5:4], voltage_enabled, state_bits[3:0]};
        // power-on of the controller applies the pending settings
        if (switch_on)
        begin
            state_nxt.src_act  = state_r.src_sel;
            state_nxt.enc_pos  = state_r.enc_pend;
            state_nxt.idx      = state_r.enc_pend % rev_w;
            state_nxt.enc_load = 1'b1;
        end
        if (par_wr)
        begin
            state_nxt.err = ~wr_ok;
            if (wr_ok)
            begin
                case (par_addr)
                    drive_param_pkg::ADDR_CTL_WORD:
                        state_nxt.ctl = par_wdata[drive_param_pkg::CW_USED_BITS-1:0];
                    drive_param_pkg::ADDR_OP_MODE: state_nxt.mode = wlo;
                    drive_param_pkg::ADDR_CMD_SRC:
                    begin
                        state_nxt.src_sel = wlo[1:0];
                        // first setup: leaving "undefined" acts at once
                        if (state_r.src_act == drive_param_pkg::SRC_NONE && !switch_on)
                            state_nxt.src_act = wlo[1:0];
                    end
                    drive_param_pkg::ADDR_ENC_POS: state_nxt.enc_pend = par_wdata;
                    drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES: state_nxt.encoder_simulation_output = wlo;
                    default: state_nxt.encoder_simulation_output = state_r.encoder_simulation_output;
                endcase
            end
        end
        else if (par_rd)
        begin
            state_nxt.rdata = 32'h00000000;
            case (par_addr)
                // reserved control bits always read back as zero
                drive_param_pkg::ADDR_CTL_WORD: state_nxt.rdata = {23'h000000, state_r.ctl};
                drive_param_pkg::ADDR_OP_MODE:  state_nxt.rdata = {{16{state_r.mode[15]}}, state_r.mode};
                drive_param_pkg::ADDR_STS_WORD: state_nxt.rdata = {16'h0000, state_r.status};
                drive_param_pkg::ADDR_CMD_SRC:  state_nxt.rdata = {30'h00000000, state_r.src_sel};
                drive_param_pkg::ADDR_ENC_POS:  state_nxt.rdata = state_r.enc_pend;
                drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES: state_nxt.rdata = {16'h0000, state_r.encoder_simulation_output};
                default: state_nxt.err = 1'b1;
            endcase
        end
    end

    // single state register; async reset to constants only
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_r          <= '0;
            state_r.ctl      <= drive_param_pkg::CTL_RESET;
            state_r.mode     <= drive_param_pkg::MODE_RESET;
            state_r.src_sel  <= drive_param_pkg::SRC_NONE;
            state_r.src_act  <= drive_param_pkg::SRC_NONE;
            state_r.enc_pend <= drive_param_pkg::ENC_RESET;
            state_r.enc_pos  <= drive_param_pkg::ENC_RESET;
            state_r.encoder_simulation_output     <= drive_param_pkg::ENCODER_SIMULATION_OUTPUT_RESET;
        end
        else
            state_r <= state_nxt;
    end

    // outputs straight from the state flops
    assign par_rdata            = state_r.rdata;
    assign par_ack              = state_r.ack;
    assign par_err              = state_r.err;
    assign ctl_switch_on        = state_r.ctl[drive_param_pkg::CW_SWITCH_ON];
    assign ctl_enable_voltage   = state_r.ctl[drive_param_pkg::CW_EN_VOLTAGE];
    assign ctl_quick_stop       = state_r.ctl[drive_param_pkg::CW_QUICK_STOP];
    assign ctl_enable_operation = state_r.ctl[drive_param_pkg::CW_EN_OPER];
    assign ctl_mode_bits        = state_r.ctl[drive_param_pkg::CW_MODE_LO +: 3];
    assign ctl_fault_reset      = state_r.ctl[drive_param_pkg::CW_FAULT_RESET];
    assign ctl_halt             = state_r.ctl[drive_param_pkg::CW_HALT];
    assign op_mode              = state_r.mode;
    assign cmd_source           = state_r.src_act;
    assign enc_pos_value        = state_r.enc_pos;
    assign enc_pos_load         = state_r.enc_load;
    assign index_offset         = state_r.idx;
    assign encoder_simulation_output_resolution      = state_r.encoder_simulation_output;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_wr(logic [15:0] a);
        par_wr && par_addr == a;
    endsequence

    property p_ctl_decode;
        s_wr(drive_param_pkg::ADDR_CTL_WORD)
            |=> ctl_halt == $past(par_wdata[8]) && ctl_switch_on == $past(par_wdata[0]);
    endproperty
    a_ctl_decode: assert property (p_ctl_decode) else $error("control word not decoded");

    property p_mode_bad;
        s_wr(drive_param_pkg::ADDR_OP_MODE) ##0 (par_wdata[15:0] == 16'h0002)
            |=> par_err && $stable(op_mode);
    endproperty
    a_mode_bad: assert property (p_mode_bad) else $error("bad mode code accepted");

    property p_status_halt;
        ctl_halt |=> par_rd && !par_wr && par_addr == drive_param_pkg::ADDR_STS_WORD ##0 1'b1
            |=> par_rdata[8];
    endproperty
    a_status_halt: assert property (p_status_halt) else $error("halt not in status");

    property p_status_ro;
        s_wr(drive_param_pkg::ADDR_STS_WORD) |=> par_ack && par_err;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write not refused");

    // reserved status bit 11 and the unused upper half never read as set
    property p_status_rsvd;
        par_rd && !par_wr && par_addr == drive_param_pkg::ADDR_STS_WORD
            |=> par_rdata[31:16] == 16'h0000 && !par_rdata[11];
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("status reserved bit set");

    // upper control bits are never stored, so a readback shows them clear
    property p_ctl_rsvd;
        par_rd && !par_wr && par_addr == drive_param_pkg::ADDR_CTL_WORD
            |=> par_rdata[31:9] == 23'h000000;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control reserved bits set");

    property p_src_range;
        s_wr(drive_param_pkg::ADDR_CMD_SRC) ##0 (par_wdata[15:0] > 16'h0003) |=> par_err;
    endproperty
    a_src_range: assert property (p_src_range) else $error("source code out of range");

    property p_src_defer;
        s_wr(drive_param_pkg::ADDR_CMD_SRC) ##0 (cmd_source != 2'h0 && !switch_on)
            |=> $stable(cmd_source);
    endproperty
    a_src_defer: assert property (p_src_defer) else $error("source changed before power-on");

    property p_src_first;
        // a coinciding switch-on applies the stored code instead
        s_wr(drive_param_pkg::ADDR_CMD_SRC)
            ##0 (cmd_source == 2'h0 && par_wdata[15:2] == 14'h0000 && !switch_on)
            |=> cmd_source == $past(par_wdata[1:0]);
    endproperty
    a_src_first: assert property (p_src_first) else $error("first setup source not taken");

    property p_enc_range;
        s_wr(drive_param_pkg::ADDR_ENC_POS) ##0 (!multi_turn_sensor && par_wdata > st_max)
            |=> par_err;
    endproperty
    a_enc_range: assert property (p_enc_range) else $error("encoder position over limit");

    property p_enc_defer;
        s_wr(drive_param_pkg::ADDR_ENC_POS) ##0 !switch_on
            |=> !enc_pos_load && $stable(enc_pos_value);
    endproperty
    a_enc_defer: assert property (p_enc_defer) else $error("encoder applied early");

    property p_enc_apply;
        switch_on |=> enc_pos_load && index_offset == enc_pos_value % rev_w;
    endproperty
    a_enc_apply: assert property (p_enc_apply) else $error("index not moved");

    property p_encoder_simulation_output_legacy;
        s_wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES)
            ##0 (legacy_firmware && par_wdata[15:0] == 16'h00c0)
            |=> par_err;
    endproperty
    a_encoder_simulation_output_legacy: assert property (p_encoder_simulation_output_legacy) else $error("legacy accepted non power");

    property p_encoder_simulation_output_new;
        s_wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES)
            ##0 (!legacy_firmware && par_wdata[15:0] >= 16'h0008)
            |=> encoder_simulation_output_resolution == $past(par_wdata[15:0]);
    endproperty
    a_encoder_simulation_output_new: assert property (p_encoder_simulation_output_new) else $error("resolution not stored");

    // below eight increments the newer firmware refuses and keeps the old value
    property p_encoder_simulation_output_floor;
        s_wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES)
            ##0 (!legacy_firmware && par_wdata[15:0] < 16'h0008)
            |=> par_err && $stable(encoder_simulation_output_resolution);
    endproperty
    a_encoder_simulation_output_floor: assert property (p_encoder_simulation_output_floor) else $error("resolution floor not kept");
endmodule : drive_param_control_bank

/* File: design/drive_param_pkg.sv */
// constants for the drive parameter bank: addresses, fields, codes, resets
package drive_param_pkg;
    // parameter addresses as seen over the fieldbus parameter port
    localparam logic [15:0] ADDR_CMD_SRC  = 16'h0502;
    localparam logic [15:0] ADDR_ENCODER_SIMULATION_OUTPUT_RES = 16'h052a;
    localparam logic [15:0] ADDR_ENC_POS  = 16'h052c;
    localparam logic [15:0] ADDR_CTL_WORD = 16'h1b02;
    localparam logic [15:0] ADDR_STS_WORD = 16'h1b04;
    localparam logic [15:0] ADDR_OP_MODE  = 16'h1b06;
    // control word bit positions
    localparam int CW_SWITCH_ON   = 0;
    localparam int CW_EN_VOLTAGE  = 1;
    localparam int CW_QUICK_STOP  = 2;
    localparam int CW_EN_OPER     = 3;
    localparam int CW_MODE_LO     = 4;
    localparam int CW_FAULT_RESET = 7;
    localparam int CW_HALT        = 8;
    localparam int CW_USED_BITS   = 9;
    // status word bit positions
    localparam int SW_VOLTAGE  = 4;
    localparam int SW_WARNING  = 7;
    localparam int SW_HALT     = 8;
    localparam int SW_REMOTE   = 9;
    localparam int SW_TARGET   = 10;
    localparam int SW_MODE_SPC = 12;
    localparam int SW_POS_ERR  = 13;
    localparam int SW_BIT14    = 14;
    localparam int SW_REF_OK   = 15;
    // operating mode codes, signed 16-bit
    localparam logic [15:0] MODE_PROFILE_POS = 16'h0001;
    localparam logic [15:0] MODE_PROFILE_VEL = 16'h0003;
    localparam logic [15:0] MODE_HOMING      = 16'h0006;
    localparam logic [15:0] MODE_JOG         = 16'hffff;
    localparam logic [15:0] MODE_ELEC_GEAR   = 16'hfffe;
    localparam logic [15:0] MODE_CURRENT     = 16'hfffd;
    localparam logic [15:0] MODE_SPEED       = 16'hfffc;
    localparam logic [15:0] MODE_OSCILLATOR  = 16'hfff9;
    // command source codes
    localparam logic [1:0]  SRC_NONE    = 2'h0;
    localparam logic [1:0]  SRC_LOCAL   = 2'h1;
    localparam logic [1:0]  SRC_CANOPEN = 2'h2;
    localparam logic [1:0]  SRC_MODBUS  = 2'h3;
    localparam logic [15:0] SRC_MAX     = 16'h0003;
    // encoder position and simulation limits
    localparam int          USR_PER_REV   = 16384;
    localparam int          MULTI_TURNS   = 4096;
    localparam logic [15:0] ENCODER_SIMULATION_OUTPUT_MIN      = 16'h0008;
    localparam logic [15:0] ENCODER_SIMULATION_OUTPUT_LEG_MIN  = 16'h0080;
    localparam logic [15:0] ENCODER_SIMULATION_OUTPUT_LEG_MAX  = 16'h1000;
    // reset values
    localparam logic [15:0] ENCODER_SIMULATION_OUTPUT_RESET    = 16'h1000;
    localparam logic [8:0]  CTL_RESET     = 9'h000;
    localparam logic [15:0] MODE_RESET    = 16'h0000;
    localparam logic [31:0] ENC_RESET     = 32'h00000000;
endpackage : drive_param_pkg

/* File: testbench/fieldbus_master_model.sv */
// fieldbus master model driving the parameter port of the drive bank
`timescale 1ns/10ps
module fieldbus_master_model (
    input  wire logic        sys_clk,
    output logic      [15:0] par_addr,
    output logic             par_wr,
    output logic             par_rd,
    output logic      [31:0] par_wdata,
    input  wire logic [31:0] par_rdata,
    input  wire logic        par_ack,
    input  wire logic        par_err
);
    // idle port after power-up
    initial
    begin
        par_addr  = 16'h0000;
        par_wr    = 1'b0;
        par_rd    = 1'b0;
        par_wdata = 32'h00000000;
    end

    // one-cycle strobe, answer taken one cycle later; strobes are driven
    // and released on falling clock edges
    task automatic access(input logic wr, input logic [15:0] a, input logic [31:0] d,
                          output logic ack, output logic err, output logic [31:0] q);
        @(negedge sys_clk);
        par_addr  = a;
        par_wdata = d;
        par_wr    = wr;
        par_rd    = ~wr;
        @(negedge sys_clk);
        ack       = par_ack;
        err       = par_err;
        q         = par_rdata;
        par_wr    = 1'b0;
        par_rd    = 1'b0;
        // released lines flip so a stale value is never mistaken for live data
        par_addr  = ~a;
        par_wdata = ~d;
    endtask : access
endmodule : fieldbus_master_model

/* File: testbench/test_drive_param_control_bank.sv */
// self-checking bench for the drive parameter bank
`timescale 1ns/10ps
module test_drive_param_control_bank;
    localparam int upr   = 16384;
    localparam int turns = 4096;
    logic        sys_clk, reset, par_wr, par_rd, par_ack, par_err, switch_on;
    logic        multi_turn_sensor, legacy_firmware, voltage_enabled, warning;
    logic        target_reached, mode_specific, position_error, status_bit14;
    logic        reference_valid, ctl_switch_on, ctl_enable_voltage, ctl_quick_stop;
    logic        ctl_enable_operation, ctl_fault_reset, ctl_halt, enc_pos_load;
    logic [15:0] par_addr, op_mode, encoder_simulation_output_resolution;
    logic [31:0] par_wdata, par_rdata, enc_pos_value, index_offset;
    logic [5:0]  state_bits;
    logic [2:0]  ctl_mode_bits;
    logic [1:0]  cmd_source;
    logic [15:0] modes [8] = '{16'h0001, 16'h0003, 16'h0006, 16'hffff,
                               16'hfffe, 16'hfffd, 16'hfffc, 16'hfff9};
    int          fail_count  = 0;
    int          check_count = 0;
    int          cycles      = 0;

    fieldbus_master_model i_master (.sys_clk(sys_clk), .par_addr(par_addr), .par_wr(par_wr),
        .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
        .par_err(par_err));

    drive_param_control_bank #(.usr_per_rev(upr), .multi_turns(turns)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .par_addr(par_addr), .par_wr(par_wr),
        .par_rd(par_rd), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_ack(par_ack),
        .par_err(par_err), .switch_on(switch_on), .multi_turn_sensor(multi_turn_sensor),
        .legacy_firmware(legacy_firmware), .state_bits(state_bits),
        .voltage_enabled(voltage_enabled), .warning(warning),
        .target_reached(target_reached), .mode_specific(mode_specific),
        .position_error(position_error), .status_bit14(status_bit14),
        .reference_valid(reference_valid), .ctl_switch_on(ctl_switch_on),
        .ctl_enable_voltage(ctl_enable_voltage), .ctl_quick_stop(ctl_quick_stop),
        .ctl_enable_operation(ctl_enable_operation), .ctl_mode_bits(ctl_mode_bits),
        .ctl_fault_reset(ctl_fault_reset), .ctl_halt(ctl_halt), .op_mode(op_mode),
        .cmd_source(cmd_source), .enc_pos_value(enc_pos_value), .enc_pos_load(enc_pos_load),
        .index_offset(index_offset), .encoder_simulation_output_resolution(encoder_simulation_output_resolution));

    // 25 MHz clock
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        logic        ack;
        logic        err;
        logic [31:0] q;
        i_master.access(1'b1, a, d, ack, err, q);
        check({30'h0, ack, err}, {30'h0, 1'b1, e});
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic e);
        logic        ack;
        logic        err;
        logic [31:0] q;
        i_master.access(1'b0, a, 32'h0, ack, err, q);
        check({30'h0, ack, err}, {30'h0, 1'b1, e});
        check(q, exp);
    endtask : rd

    // switch-on pulse; the load strobe answers one cycle later
    task automatic power_on;
        @(negedge sys_clk);
        switch_on = 1'b1;
        @(negedge sys_clk);
        switch_on = 1'b0;
        check({31'h0, enc_pos_load}, 32'h1);
    endtask : power_on

    function automatic logic [31:0] ctl();
        return {23'h0, ctl_halt, ctl_fault_reset, ctl_mode_bits, ctl_enable_operation,
                ctl_quick_stop, ctl_enable_voltage, ctl_switch_on};
    endfunction : ctl

    // expected status, halt set by the earlier control write
    function automatic logic [31:0] sts(input logic rem);
        return {16'h0, reference_valid, status_bit14, position_error, mode_specific, 1'b0,
                target_reached, rem, 1'b1, warning, state_bits[5:4], voltage_enabled,
                state_bits[3:0]};
    endfunction : sts

    // main sequence
    initial
    begin
        reset = 1'b1;
        switch_on = 1'b0;
        multi_turn_sensor = 1'b0;
        legacy_firmware = 1'b1;
        state_bits = 6'h2b;
        {voltage_enabled, warning, target_reached, mode_specific} = 4'h9;
        {position_error, status_bit14, reference_valid} = 3'h5;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        check({16'h0, encoder_simulation_output_resolution}, 32'h1000);
        rd(drive_param_pkg::ADDR_CMD_SRC, 32'h0, 1'b0);
        rd(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h1000, 1'b0);
        rd(drive_param_pkg::ADDR_CTL_WORD, 32'h0, 1'b0);
        rd(16'h0600, 32'h0, 1'b1);
        $display("test reset done");
        wr(drive_param_pkg::ADDR_CTL_WORD, 32'h155, 1'b0);
        check(ctl(), 32'h155);
        wr(drive_param_pkg::ADDR_CTL_WORD, 32'h1ff, 1'b0);
        check(ctl(), 32'h1ff);
        rd(drive_param_pkg::ADDR_CTL_WORD, 32'h1ff, 1'b0);
        $display("test control done");
        foreach (modes[i])
        begin
            wr(drive_param_pkg::ADDR_OP_MODE, {16'h0, modes[i]}, 1'b0);
            check({16'h0, op_mode}, {16'h0, modes[i]});
            rd(drive_param_pkg::ADDR_OP_MODE, {{16{modes[i][15]}}, modes[i]}, 1'b0);
        end
        wr(drive_param_pkg::ADDR_OP_MODE, 32'h2, 1'b1);
        check({16'h0, op_mode}, 32'hfff9);
        $display("test mode done");
        wr(drive_param_pkg::ADDR_STS_WORD, 32'h0, 1'b1);
        rd(drive_param_pkg::ADDR_STS_WORD, sts(1'b0), 1'b0);
        wr(drive_param_pkg::ADDR_CMD_SRC, 32'h2, 1'b0);
        check({30'h0, cmd_source}, 32'h2);
        {state_bits, voltage_enabled, warning, target_reached} = ~{state_bits,
            voltage_enabled, warning, target_reached};
        {mode_specific, position_error, status_bit14, reference_valid} = 4'h6;
        repeat (2) @(negedge sys_clk);
        rd(drive_param_pkg::ADDR_STS_WORD, sts(1'b1), 1'b0);
        $display("test status done");
        wr(drive_param_pkg::ADDR_CMD_SRC, 32'h3, 1'b0);
        check({30'h0, cmd_source}, 32'h2);
        wr(drive_param_pkg::ADDR_CMD_SRC, 32'h4, 1'b1);
        rd(drive_param_pkg::ADDR_CMD_SRC, 32'h3, 1'b0);
        power_on();
        check({30'h0, cmd_source}, 32'h3);
        wr(drive_param_pkg::ADDR_CMD_SRC, 32'h1, 1'b0);
        power_on();
        check({30'h0, cmd_source}, 32'h1);
        $display("test source done");
        wr(drive_param_pkg::ADDR_ENC_POS, upr - 1, 1'b0);
        check(enc_pos_value, 32'h0);
        wr(drive_param_pkg::ADDR_ENC_POS, upr, 1'b1);
        power_on();
        check(enc_pos_value, upr - 1);
        check(index_offset, upr - 1);
        multi_turn_sensor = 1'b1;
        wr(drive_param_pkg::ADDR_ENC_POS, upr * turns, 1'b1);
        wr(drive_param_pkg::ADDR_ENC_POS, upr * turns - 1, 1'b0);
        wr(drive_param_pkg::ADDR_ENC_POS, upr * 5 + 100, 1'b0);
        power_on();
        check(enc_pos_value, upr * 5 + 100);
        check(index_offset, 32'd100);
        $display("test encoder done");
        for (int s = 7; s <= 12; s++)
        begin
            wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h1 << s, 1'b0);
            check({16'h0, encoder_simulation_output_resolution}, 32'h1 << s);
        end
        wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h180, 1'b1);
        wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h2000, 1'b1);
        wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h40, 1'b1);
        check({16'h0, encoder_simulation_output_resolution}, 32'h1000);
        legacy_firmware = 1'b0;
        wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h7, 1'b1);
        wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'h8, 1'b0);
        check({16'h0, encoder_simulation_output_resolution}, 32'h8);
        wr(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'hffff, 1'b0);
        rd(drive_param_pkg::ADDR_ENCODER_SIMULATION_OUTPUT_RES, 32'hffff, 1'b0);
        $display("test resolution done");
        report_and_stop();
    end
endmodule : test_drive_param_control_bank
